// >>> tfci_pkg.sv
// constants and carrier types shared by the slot mapper files
package tfci_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_GAP    = 8'h04;
  localparam logic [7:0] ADDR_WORD   = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_ERR_POS  = 1;
  localparam int STAT_DONE_POS = 2;
  localparam int CMD_START_POS = 0;
  localparam int WORD_TOP_POS  = 29;
  localparam int CW1_LSB_POS   = 15;

  localparam logic [6:0]  CTRL_RST = 7'h00;
  localparam logic [11:0] GAP_RST  = 12'h000;
  localparam logic [29:0] WORD_RST = 30'h00000000;

  localparam logic [3:0] LAST_SLOT  = 4'he;
  localparam logic [3:0] SLOT_SPAN  = 4'he;
  localparam logic [3:0] GAP3_FIRST = 4'h3;
  localparam logic [3:0] GAP4_EMPTY = 4'h4;
  localparam logic [3:0] GAP4_FIRST = 4'h5;
  localparam logic [6:0] TOP_NARROW = 7'h1d;
  localparam logic [6:0] TOP_WIDE   = 7'h77;
  localparam logic [7:0] ORIG_BITS  = 8'h1e;
  localparam logic [7:0] WORD_MOD   = 8'h1e;
  localparam logic [4:0] ORIG_TOP   = 5'h1d;
  localparam logic [6:0] ZH_NARROW  = 7'h01;
  localparam logic [6:0] ZH_WIDE    = 7'h04;

  // bit 0 is split, bit 6 is sf_below_128
  typedef struct packed {
    logic sf_below_128;
    logic uplink;
    logic tgl4;
    logic method_b;
    logic compressed;
    logic wide;
    logic split;
  } cfg_type;

  typedef struct packed {
    logic [3:0] nbits;
    logic [3:0] last;
    logic [3:0] first;
  } gap_type;

  typedef struct packed {
    logic [6:0] start;
    logic [3:0] len;
  } plan_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EMIT = 2'b10
  } state_type;
endpackage

// >>> tfci_slot_plan.sv
// per-slot bit count for the active mode, and first sequence index in every mode but method B, where start stays at top
`timescale 1ns/1ns
`default_nettype none
module tfci_slot_plan
  import tfci_pkg::*;
(
  input  wire cfg_type    i_cfg,
  input  wire gap_type    i_gap,
  input  wire logic [3:0] i_slot,
  output var  plan_type   o_plan
);
  logic [6:0] zh;
  logic [6:0] top;
  logic [6:0] z2;
  logic [6:0] z3;
  logic [6:0] z5;
  logic [6:0] sl;
  logic [6:0] rel;
  logic [6:0] x;

  assign zh  = i_cfg.wide ? ZH_WIDE : ZH_NARROW;
  assign top = i_cfg.wide ? TOP_WIDE : TOP_NARROW;
  assign z2  = 7'(zh * 7'h02);
  assign z3  = 7'(zh * 7'h03);
  assign z5  = 7'(zh * 7'h05);
  assign sl  = {3'h0, i_slot};

  always_comb begin
    o_plan = '0;
    rel    = 7'h00;
    x      = 7'h00;
    if (!i_cfg.compressed) begin
      o_plan.start = 7'(top - 7'(z2 * sl));
      o_plan.len   = z2[3:0];
    end else if (i_cfg.method_b) begin
      o_plan.start = top;
      // gap slots carry nothing, others take the widened field
      if (i_slot < i_gap.first || i_slot > i_gap.last) begin
        o_plan.len = i_gap.nbits;
      end
    end else if (!i_cfg.tgl4) begin
      if (i_slot >= GAP3_FIRST) begin
        rel = 7'(sl - {3'h0, GAP3_FIRST});
        x   = rel >> 1;
        if (!rel[0]) begin
          o_plan.start = 7'(top - 7'(z5 * x));
          o_plan.len   = z3[3:0];
        end else begin
          o_plan.start = 7'(top - z3 - 7'(z5 * x));
          o_plan.len   = z2[3:0];
        end
      end
    end else if (i_slot >= GAP4_FIRST) begin
      x            = 7'(sl - {3'h0, GAP4_FIRST});
      o_plan.start = 7'(top - 7'(z3 * x));
      o_plan.len   = z3[3:0];
    end
  end
endmodule
`default_nettype wire

// >>> tfci_slot_mapper.sv
// slot mapper top: register slave, frame sequencer and bit stream out
`timescale 1ns/1ns
`default_nettype none
module tfci_slot_mapper
  import tfci_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  input  wire logic        i_ready,
  output var  logic        o_valid,
  output var  logic        o_bit,
  output var  logic [3:0]  o_slot
);
  cfg_type     cfg_r;
  gap_type     gap_r;
  logic [29:0] word_r;
  logic        err_r;
  logic        done_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic        pready_r;
  logic        pslverr_r;
  state_type   state_r;
  logic [3:0]  slot_r;
  logic [3:0]  pos_r;
  logic [7:0]  seq_r;
  logic        valid_r;
  logic        bit_r;
  logic [3:0]  slot_out_r;
  logic [3:0]  out_pos_r;
  logic        first_r;
  logic        first_out_r;
  plan_type    plan;

  logic        setup;
  logic        wr_en;
  logic        busy;
  logic        start_req;
  logic        start_ok;
  logic        start_bad;
  logic        clr_stat;
  logic        cfg_bad;
  logic        can_load;
  logic        last_pos;
  logic        emit;
  logic        finish;
  logic [7:0]  blk;
  logic [4:0]  e_idx;
  logic [7:0]  rep_j;
  logic [4:0]  rep_m;
  logic [6:0]  b_idx;
  logic [6:0]  c_idx;
  logic [3:0]  tx_slots;
  logic [7:0]  d_total;

  function automatic logic addr_known(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == ADDR_CTRL) begin
      hit = 1'b1;
    end else if (a == ADDR_GAP) begin
      hit = 1'b1;
    end else if (a == ADDR_WORD) begin
      hit = 1'b1;
    end else if (a == ADDR_CMD) begin
      hit = 1'b1;
    end else if (a == ADDR_STATUS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // value of sequence bit idx taken out of the held code word(s)
  function automatic logic seq_bit(input logic [29:0] w,
                                   input logic [6:0]  idx,
                                   input cfg_type     c);
    logic [4:0] k;
    logic       sub;
    k   = 5'h00;
    sub = 1'b0;
    if (!c.split) begin
      k = c.wide ? idx[6:2] : idx[4:0];
      return w[k];
    end
    k   = c.wide ? {1'b0, idx[6:3]} : idx[5:1];
    sub = c.wide ? idx[2] : idx[0];
    // upper half of the sub-group is the first word
    return sub ? w[5'(k + 5'(CW1_LSB_POS))] : w[k];
  endfunction

  assign setup     = i_psel & ~i_penable;
  assign wr_en     = i_psel & i_penable & i_pwrite & pready_r;
  assign busy      = (state_r == ST_EMIT);
  assign start_req = wr_en & (i_paddr == ADDR_CMD) & i_pwdata[CMD_START_POS];
  assign start_ok  = start_req & ~busy & ~cfg_bad;
  assign start_bad = start_req & ~busy & cfg_bad;
  assign clr_stat  = wr_en & (i_paddr == ADDR_STATUS);

  // transmitted slots and field total of an uplink compressed frame
  assign tx_slots = 4'(SLOT_SPAN + gap_r.first - gap_r.last);
  // operands widened first so the product keeps its upper bits
  assign d_total  = 8'({4'h0, gap_r.nbits} * {4'h0, tx_slots});

  always_comb begin
    cfg_bad = 1'b0;
    if (cfg_r.wide && (cfg_r.uplink || !cfg_r.sf_below_128)) begin
      cfg_bad = 1'b1;
    end
    if (cfg_r.compressed && cfg_r.method_b) begin
      if (!cfg_r.uplink) begin
        cfg_bad = 1'b1;
      end
      // repetition wraps on 30 bits, so the field must hold them all
      if (cfg_r.wide || gap_r.first > gap_r.last ||
          gap_r.last > LAST_SLOT || d_total < ORIG_BITS) begin
        cfg_bad = 1'b1;
      end
    end
    if (cfg_r.compressed && !cfg_r.method_b && cfg_r.uplink) begin
      cfg_bad = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~addr_known(i_paddr);
      if (setup && !i_pwrite) begin
        prdata_r <= rd_nxt;
      end
    end
  end

  always_comb begin
    rd_nxt = 32'h00000000;
    if (i_paddr == ADDR_CTRL) begin
      rd_nxt = {25'h0000000, cfg_r};
    end else if (i_paddr == ADDR_GAP) begin
      rd_nxt = {20'h00000, gap_r};
    end else if (i_paddr == ADDR_WORD) begin
      rd_nxt = {2'h0, word_r};
    end else if (i_paddr == ADDR_STATUS) begin
      rd_nxt[STAT_BUSY_POS] = busy;
      rd_nxt[STAT_ERR_POS]  = err_r;
      rd_nxt[STAT_DONE_POS] = done_r;
    end
  end

  // configuration is frozen while a frame is being sent
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r  <= CTRL_RST;
      gap_r  <= GAP_RST;
      word_r <= WORD_RST;
    end else if (wr_en && !busy) begin
      if (i_paddr == ADDR_CTRL) begin
        cfg_r <= i_pwdata[6:0];
      end else if (i_paddr == ADDR_GAP) begin
        gap_r <= i_pwdata[11:0];
      end else if (i_paddr == ADDR_WORD) begin
        word_r <= i_pwdata[29:0];
      end
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      err_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      err_r  <= start_bad |
                (err_r & ~(clr_stat & i_pwdata[STAT_ERR_POS]));
      done_r <= finish |
                (done_r & ~(clr_stat & i_pwdata[STAT_DONE_POS]));
    end
  end

  tfci_slot_plan u_plan (
    .i_cfg  (cfg_r),
    .i_gap  (gap_r),
    .i_slot (slot_r),
    .o_plan (plan)
  );

  // uplink method B: originals 29..0, then repeats wrapping from E
  assign blk   = 8'({4'h0, gap_r.first} * {4'h0, gap_r.nbits});
  assign e_idx = 5'(ORIG_TOP - 5'(blk % WORD_MOD));
  assign rep_j = 8'(seq_r - ORIG_BITS);
  assign rep_m = 5'(rep_j % WORD_MOD);

  always_comb begin
    if (seq_r < ORIG_BITS) begin
      b_idx = 7'(ORIG_BITS - 8'h01 - seq_r);
    end else if (e_idx >= rep_m) begin
      b_idx = {2'h0, 5'(e_idx - rep_m)};
    end else begin
      b_idx = 7'({2'h0, e_idx} + 7'(WORD_MOD) - {2'h0, rep_m});
    end
  end

  // descending index inside a slot puts the high bit first
  assign c_idx    = cfg_r.compressed && cfg_r.method_b ? b_idx :
                    7'(plan.start - {3'h0, pos_r});
  assign can_load = ~valid_r | i_ready;
  assign last_pos = (pos_r == 4'(plan.len - 4'h1));
  assign emit     = busy & (plan.len != 4'h0) & can_load;
  assign finish   = busy & (slot_r == LAST_SLOT) &
                    ((plan.len == 4'h0) | (can_load & last_pos));

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      slot_r  <= 4'h0;
      pos_r   <= 4'h0;
      seq_r   <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_ok) begin
            state_r <= ST_EMIT;
            slot_r  <= 4'h0;
            pos_r   <= 4'h0;
            seq_r   <= 8'h00;
          end
        end
        ST_EMIT: begin
          if (emit) begin
            seq_r <= 8'(seq_r + 8'h01);
          end
          // empty slots (gap, slot 4 of a four-slot gap) pass at once
          if (plan.len == 4'h0 || (can_load && last_pos)) begin
            pos_r <= 4'h0;
            if (slot_r == LAST_SLOT) begin
              state_r <= ST_IDLE;
            end else begin
              slot_r <= 4'(slot_r + 4'h1);
            end
          end else if (can_load) begin
            pos_r <= 4'(pos_r + 4'h1);
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // output stage holds a bit until the assembler takes it
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      valid_r     <= 1'b0;
      bit_r       <= 1'b0;
      slot_out_r  <= 4'h0;
      out_pos_r   <= 4'h0;
      first_out_r <= 1'b0;
    end else if (emit) begin
      valid_r     <= 1'b1;
      bit_r       <= seq_bit(word_r, c_idx, cfg_r);
      slot_out_r  <= slot_r;
      out_pos_r   <= pos_r;
      first_out_r <= first_r;
    end else if (i_ready) begin
      valid_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      first_r <= 1'b0;
    end else if (start_ok) begin
      first_r <= 1'b1;
    end else if (emit) begin
      first_r <= 1'b0;
    end
  end

  assign o_prdata  = prdata_r;
  assign o_pready  = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_valid   = valid_r;
  assign o_bit     = bit_r;
  assign o_slot    = slot_out_r;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_bad_dl_start;
    start_req && !busy && cfg_r.compressed && cfg_r.method_b &&
    !cfg_r.uplink;
  endsequence

  sequence s_refused;
    err_r && (state_r == ST_IDLE) ##1 (state_r == ST_IDLE);
  endsequence

  a_dl_b_refused: assert property (
    s_bad_dl_start |=> s_refused)
    else $error("downlink method B start was not refused");

  a_wide_refused: assert property (
    start_req && !busy && cfg_r.wide &&
    (cfg_r.uplink || !cfg_r.sf_below_128) |=> err_r && !busy)
    else $error("eight-bit mapping accepted outside its channel");

  a_first_bit: assert property (
    valid_r && first_out_r |-> bit_r == word_r[WORD_TOP_POS])
    else $error("frame did not open with the top code word bit");

  a_gap4_empty: assert property (
    valid_r && cfg_r.compressed && !cfg_r.method_b && cfg_r.tgl4
    |-> slot_out_r > GAP4_EMPTY)
    else $error("bit sent in a gap slot of a four-slot gap");

  a_gap3_skip: assert property (
    valid_r && cfg_r.compressed && !cfg_r.method_b && !cfg_r.tgl4
    |-> slot_out_r >= GAP3_FIRST)
    else $error("bit sent in a gap slot of a three-slot gap");

  a_out_hold: assert property (
    valid_r && !i_ready |=>
    valid_r && $stable(bit_r) && $stable(slot_out_r))
    else $error("output bit changed before it was taken");

  a_split_rep: assert property (
    valid_r && !cfg_r.compressed && cfg_r.split && cfg_r.wide |->
    bit_r == (out_pos_r < 4'h4 ?
              word_r[5'(5'd29 - {1'b0, slot_out_r})] :
              word_r[5'(5'd14 - {1'b0, slot_out_r})]))
    else $error("split repetition slot carries the wrong bit");

  a_b_gap_free: assert property (
    valid_r && cfg_r.compressed && cfg_r.method_b |->
    (slot_out_r < gap_r.first || slot_out_r > gap_r.last))
    else $error("method B bit placed inside the gap");
endmodule
`default_nettype wire

// >>> tfci_slot_sink.sv
// slot assembler model: takes offered bits with random stalls
`timescale 1ns/1ns
`default_nettype none
module tfci_slot_sink (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_valid,
  input  wire logic       i_bit,
  input  wire logic [3:0] i_slot,
  output var  logic       o_ready
);
  int         seed = 6693;
  logic [4:0] got[$];

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ready <= 1'b0;
    end else begin
      if (i_valid && o_ready) begin
        got.push_back({i_slot, i_bit});
      end
      // one cycle in four stalls, so held bits must wait
      o_ready <= ($random(seed) % 4) != 0;
    end
  end
endmodule
`default_nettype wire

// >>> tfci_slot_mapper_test.sv
// self-checking bench for the slot mapper
`timescale 1ns/1ns
`default_nettype none
module tfci_slot_mapper_test;
  import tfci_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        pen     = 1'b0;
  logic        pwr     = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ready;
  logic        valid;
  logic        obit;
  logic [3:0]  slot;
  int          seed    = 6693;
  int          fails   = 0;
  int          num_checks = 0;
  logic [4:0]  exp_q[$];
  logic [31:0] q;
  logic        e;

  tfci_slot_mapper i_tfci_slot_mapper (
    .i_ref_clk (ref_clk),
    .i_rst     (rst),
    .i_psel    (psel),
    .i_penable (pen),
    .i_pwrite  (pwr),
    .i_paddr   (paddr),
    .i_pwdata  (pwdata),
    .o_prdata  (prdata),
    .o_pready  (pready),
    .o_pslverr (pslverr),
    .i_ready   (ready),
    .o_valid   (valid),
    .o_bit     (obit),
    .o_slot    (slot)
  );

  tfci_slot_sink i_tfci_slot_sink (
    .i_ref_clk (ref_clk),
    .i_rst     (rst),
    .i_valid   (valid),
    .i_bit     (obit),
    .i_slot    (slot),
    .o_ready   (ready)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] want, input string m);
    num_checks++;
    if (got !== want) begin
      fails++;
      $display("Error %0t: %s got %h want %h", $time, m, got, want);
    end
  endtask

  task timeout(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      $display("Error %0t: wait ran out", $time);
      end_of_test();
    end
  endtask

  // request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    timeout(n, 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] want, input string m);
    apb(1'b0, a, 32'h00000000);
    chk(q, want, m);
  endtask

  function automatic logic cbit(cfg_type c, logic [29:0] w, int idx);
    int m;
    m = c.wide ? idx / 4 : idx;
    if (c.split) return (m % 2) ? w[15 + m / 2] : w[m / 2];
    return w[m];
  endfunction

  function automatic int nslot(cfg_type c, gap_type g, int s);
    int z;
    z = c.wide ? 8 : 2;
    if (c.compressed && c.method_b)
      return (s >= g.first && s <= g.last) ? 0 : int'(g.nbits);
    if (!c.compressed) return z;
    if (c.tgl4) return (s < 5) ? 0 : z * 3 / 2;
    return (s < 3) ? 0 : ((s % 2) ? z * 3 / 2 : z);
  endfunction

  task build(input cfg_type c, input gap_type g, input logic [29:0] w);
    int p;
    int ee;
    int ix;
    exp_q.delete();
    p = 0;
    ee = 29 - (int'(g.first) * int'(g.nbits)) % 30;
    for (int s = 0; s < 15; s++) begin
      for (int k = 0; k < nslot(c, g, s); k++) begin
        if (!(c.compressed && c.method_b)) ix = (c.wide ? 119 : 29) - p;
        else if (p < 30) ix = 29 - p;
        else ix = ((ee - (p - 30)) % 30 + 30) % 30;
        exp_q.push_back({4'(s), cbit(c, w, ix)});
        p++;
      end
    end
  endtask

  task frame(input cfg_type c, input gap_type g, input logic bad);
    logic [29:0] w;
    int          n;
    w = 30'($random(seed));
    apb(1'b1, ADDR_CTRL, 32'(c));
    apb(1'b1, ADDR_GAP, 32'(g));
    apb(1'b1, ADDR_WORD, 32'(w));
    build(c, g, w);
    i_tfci_slot_sink.got.delete();
    apb(1'b1, ADDR_CMD, 32'h00000001);
    if (bad) begin
      rd(ADDR_STATUS, 32'h00000002, "refused start");
      apb(1'b1, ADDR_STATUS, 32'h00000002);
      exp_q.delete();
    end else begin
      // config writes during a frame must not disturb it
      apb(1'b1, ADDR_CTRL, 32'h00000000);
      n = 0;
      do begin
        apb(1'b0, ADDR_STATUS, 32'h00000000);
        n++;
      end while (q[STAT_DONE_POS] !== 1'b1 && n < 200);
      timeout(n, 200);
      for (n = 0; n < 400; n++) begin
        if (i_tfci_slot_sink.got.size() >= exp_q.size()) break;
        @(posedge ref_clk);
      end
      timeout(n, 400);
      rd(ADDR_CTRL, 32'(c), "ctrl kept while busy");
      rd(ADDR_STATUS, 32'h00000004, "done only");
      apb(1'b1, ADDR_STATUS, 32'h00000004);
    end
    repeat (10) @(posedge ref_clk);
    chk(i_tfci_slot_sink.got.size(), exp_q.size(), "bit count");
    foreach (exp_q[i]) begin
      chk(32'(i_tfci_slot_sink.got[i]), 32'(exp_q[i]), "slot and bit");
    end
    rd(ADDR_STATUS, 32'h00000000, "status cleared");
    $display("frame ctrl %h gap %h finished", c, g);
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, 32'(CTRL_RST), "ctrl reset");
    rd(ADDR_GAP, 32'(GAP_RST), "gap reset");
    rd(ADDR_WORD, 32'(WORD_RST), "word reset");
    rd(ADDR_STATUS, 32'h00000000, "status reset");
    rd(ADDR_CMD, 32'h00000000, "cmd reads zero");
    apb(1'b0, 8'h14, 32'h00000000);
    chk(32'(e), 32'h00000001, "unmapped error");
    chk(q, 32'h00000000, "unmapped data");
    apb(1'b1, ADDR_GAP, 32'hffffffff);
    rd(ADDR_GAP, 32'h00000fff, "gap width");
    $display("register test finished");
    frame(7'h00, 12'h000, 1'b0);
    frame(7'h01, 12'h000, 1'b0);
    frame(7'h42, 12'h000, 1'b0);
    frame(7'h43, 12'h000, 1'b0);
    frame(7'h04, 12'h000, 1'b0);
    frame(7'h05, 12'h000, 1'b0);
    frame(7'h46, 12'h000, 1'b0);
    frame(7'h57, 12'h000, 1'b0);
    frame(7'h14, 12'h000, 1'b0);
    frame(7'h2c, 12'h497, 1'b0);
    frame(7'h2d, 12'h420, 1'b0);
    frame(7'h2c, 12'h3ec, 1'b0);
    frame(7'h0c, 12'h497, 1'b1);
    frame(7'h02, 12'h000, 1'b1);
    frame(7'h24, 12'h000, 1'b1);
    frame(7'h2c, 12'h219, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
